// ===== hw/cvs_regs.sv
// Buck-boost control and ramp control registers with blanking and ramp sequencing
// How it works
// - Buck-boost register at 0x19, reset 0x94
// - Buck-boost writes land only while unlocked by password
// - Any landed buck-boost write blanks monitors 5 ms
// - Power-up voltage code follows resistor select
// - Bit 7 chooses light-load pulse mode
// - Bits 5:0 hold voltage code, reset 14h
// - Ramp register at 0x1A, reset 0x06
// - Ramp limiting only for first two bucks
// - Commit starts ramp, self-clears at end
// - Bypass starts ramp on a core write while no ramp runs
// - Ramp codes set step time, 7 immediate
`timescale 1ns/1ps
module cvs_regs
  import cvs_pkg::*;
#(
  parameter int BLANK_CYC = cvs_pkg::CVS_BLANK_CYC  // Blanking length, shorten in simulation
) (
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RSTN,
  // Register access from the serial engine
  input  wire logic       WR_EN,
  input  wire logic       RD_EN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  output logic      [7:0] RDATA,
  // Password state and core buck writes
  input  wire logic       UNLOCKED,
  input  wire logic       CORE_CODE_WR,
  input  wire logic [7:0] CORE_STEPS,
  // Power-up strap from the resistor select pin
  input  wire logic       RESISTOR_DEFAULT_SELECT,
  input  wire logic [5:0] STRAP_ALT_CODE,
  // Controls to the converters
  output logic            BUCKBOOST_PFM,
  output logic      [5:0] BUCKBOOST_CODE,
  output logic            BUCKBOOST_MON_BLANK,
  output logic            CORE_RAMP_ACTIVE,
  output logic            CORE_APPLY
);
  import cvs_pkg::*;

  // Ramp handshake between the bank and the step timer
  cvs_ramp_if rp ();

  // Strap capture
  logic [1:0]             strap_sync_q;            // Strap synchroniser
  logic [1:0]             settle_q;                // Both sync stages loaded
  logic                   strap_done_q, strap_done_d;
  // Register fields
  logic                   bb_pfm_q, bb_pfm_d;      // Light-load enable
  logic [5:0]             bb_code_q, bb_code_d;    // Buck-boost voltage code
  logic                   go_q, go_d;              // Commit bit
  logic                   byp_q, byp_d;            // Commit bypass bit
  logic [2:0]             rate_q, rate_d;          // Ramp code
  // Monitor blanking
  logic [CVS_BLANK_W-1:0] blank_q, blank_d;        // Blanking counter
  logic                   blank_on_q, blank_on_d;  // Registered blank flag
  // One-cycle pulses toward the timer and the core bucks, and held read data
  logic                   start_q, start_d;        // Ramp start pulse
  logic                   apply_q, apply_d;        // Apply pulse to core bucks
  logic [7:0]             rdata_q, rdata_d;        // Read data

  // Address match used by both write and read paths
  // Kept as a function so the two decoders can never drift apart
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // Strap pin crosses in through two flops; only the second stage is read.
  // The settle marks run beside them so the strap is taken once both
  // stages hold the pin, never while they still hold the reset zeros.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      strap_sync_q <= 2'b00;
      settle_q     <= 2'b00;
    end else begin
      strap_sync_q <= {strap_sync_q[0], RESISTOR_DEFAULT_SELECT};
      settle_q     <= {settle_q[0], 1'b1};
    end
  end

  // Next values of the register bank
  // Later branches override earlier ones, which sets every priority below
  always_comb begin
    logic wr_bb;
    logic wr_rp;
    // Decoded strobes; the password gates only the buck-boost register
    wr_bb        = WR_EN && UNLOCKED && hit(ADDR, CVS_BB_ADDR);
    wr_rp        = WR_EN && hit(ADDR, CVS_RAMP_ADDR);
    // Strap window closes for good once the settle marks are full
    strap_done_d = strap_done_q | settle_q[1];
    // Everything else holds by default; the pulses fall back to zero
    bb_pfm_d     = bb_pfm_q;
    bb_code_d    = bb_code_q;
    go_d         = go_q;
    byp_d        = byp_q;
    rate_d       = rate_q;
    start_d      = 1'b0;
    apply_d      = 1'b0;
    blank_d      = blank_q;
    rdata_d      = rdata_q;
    // Strap taken once, on the first edge after both sync stages settle;
    // a write in that same cycle still wins, as it is applied further down
    if (!strap_done_q && settle_q[1] && strap_sync_q[1]) begin
      bb_code_d = STRAP_ALT_CODE;
    end
    // Blanking countdown, one step per clock
    if (blank_q != '0) begin
      blank_d = blank_q - CVS_BLANK_W'(1);
    end
    // Buck-boost write: only while the password is satisfied
    if (wr_bb) begin
      bb_pfm_d  = WDATA[CVS_BB_PFM_BIT];
      bb_code_d = WDATA[5:0];
      // Every landed write restarts the full blanking span
      blank_d   = CVS_BLANK_W'(BLANK_CYC);
    end
    // End of transition clears commit and applies the set-point;
    // placed before the write so a new commit in the same cycle wins
    if (rp.done) begin
      go_d    = 1'b0;
      apply_d = 1'b1;
    end
    // Ramp register write is not password gated
    if (wr_rp) begin
      byp_d  = WDATA[CVS_BYPASS_BIT];
      rate_d = WDATA[2:0];
      // Commit while a ramp runs is dropped rather than queued
      if (WDATA[CVS_GO_BIT] && !rp.busy) begin
        go_d    = 1'b1;
        start_d = 1'b1;
      end
    end
    // Bypass: a core code write launches the ramp by itself
    if (byp_q && CORE_CODE_WR && !rp.busy && !start_q) begin
      start_d = 1'b1;
    end
    // Blank flag follows the counter's next value, so it stays a flop output
    blank_on_d = (blank_d != '0);
    // Read mux, reserved bits zero
    // Data is registered here and stands until the next read strobe
    if (RD_EN) begin
      if (hit(ADDR, CVS_BB_ADDR)) begin
        rdata_d = {bb_pfm_q, 1'b0, bb_code_q} & CVS_BB_WMASK;
      end else if (hit(ADDR, CVS_RAMP_ADDR)) begin
        // Commit reads back high until the ramp ends
        rdata_d = {go_q, byp_q, 3'b000, rate_q} & CVS_RAMP_WMASK;
      end else begin
        // Unmapped subaddress reads as zero
        rdata_d = 8'h00;
      end
    end
  end

  // Register bank flops
  // Reset values come from the package; a strap override lands a few
  // edges later, once the synchroniser has settled
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      strap_done_q <= 1'b0;
      bb_pfm_q     <= CVS_BB_RESET[CVS_BB_PFM_BIT];
      bb_code_q    <= CVS_BB_RESET[5:0];
      go_q         <= CVS_RAMP_RESET[CVS_GO_BIT];
      byp_q        <= CVS_RAMP_RESET[CVS_BYPASS_BIT];
      rate_q       <= CVS_RAMP_RESET[2:0];
      blank_q      <= '0;
      blank_on_q   <= 1'b0;
      start_q      <= 1'b0;
      apply_q      <= 1'b0;
      rdata_q      <= 8'h00;
    end else begin
      strap_done_q <= strap_done_d;
      bb_pfm_q     <= bb_pfm_d;
      bb_code_q    <= bb_code_d;
      go_q         <= go_d;
      byp_q        <= byp_d;
      rate_q       <= rate_d;
      blank_q      <= blank_d;
      blank_on_q   <= blank_on_d;
      start_q      <= start_d;
      apply_q      <= apply_d;
      rdata_q      <= rdata_d;
    end
  end

  // Ramp timing only paces the two core bucks; buck-boost code goes straight out
  // The third buck lives outside this block and takes no ramp either
  assign rp.start = start_q;
  assign rp.rate  = rate_q;

  // Step timer; the core step count is sampled once, when the ramp starts
  cvs_ramp_timer u_timer (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .steps (CORE_STEPS),
    .rp    (rp)
  );

  // Output flops
  // Busy is registered again so the active flag is a clean flop output,
  // at the cost of one cycle of lag behind the timer
  logic ramp_q;  // Registered busy
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ramp_q <= 1'b0;
    end else begin
      ramp_q <= rp.busy;
    end
  end

  // Top outputs, each straight from a flop
  assign RDATA               = rdata_q;
  assign BUCKBOOST_PFM       = bb_pfm_q;
  assign BUCKBOOST_CODE      = bb_code_q;
  assign BUCKBOOST_MON_BLANK = blank_on_q;
  assign CORE_RAMP_ACTIVE    = ramp_q;
  assign CORE_APPLY          = apply_q;
endmodule : cvs_regs

// ===== hw/cvs_pkg.sv
// Package: offsets, fields, reset values and timing for the converter register pair
package cvs_pkg;
  // Register subaddresses
  localparam logic [7:0] CVS_BB_ADDR      = 8'h19;
  localparam logic [7:0] CVS_RAMP_ADDR    = 8'h1A;
  // Reset values
  localparam logic [7:0] CVS_BB_RESET     = 8'h94;
  localparam logic [7:0] CVS_RAMP_RESET   = 8'h06;
  // Field positions
  localparam int         CVS_BB_PFM_BIT   = 7;
  localparam int         CVS_GO_BIT       = 7;
  localparam int         CVS_BYPASS_BIT   = 6;
  // Writable masks (reserved bits cleared)
  localparam logic [7:0] CVS_BB_WMASK     = 8'hBF;
  localparam logic [7:0] CVS_RAMP_WMASK   = 8'hC7;
  // Voltage code limits
  localparam logic [5:0] CVS_BB_CODE_MAX  = 6'h34;
  localparam logic [5:0] CVS_BB_CODE_RST  = 6'h14;
  // Ramp code for immediate change
  localparam logic [2:0] CVS_RAMP_IMMED   = 3'h7;
  // Clock and timing
  localparam int         CVS_CLK_KHZ      = 10_000;
  localparam int         CVS_BLANK_MS     = 5;
  localparam int         CVS_BLANK_CYC    = CVS_BLANK_MS * CVS_CLK_KHZ;
  // Shortest step of 2.5 us expressed in ns
  localparam int         CVS_STEP_MIN_NS  = 2500;
  localparam int         CVS_STEP_MIN_CYC = CVS_STEP_MIN_NS * CVS_CLK_KHZ / 1_000_000;
  localparam int         CVS_STEP_W       = 11;
  localparam int         CVS_BLANK_W      = 16;
endpackage : cvs_pkg

// ===== hw/cvs_ramp_if.sv
// Interface: ramp request and progress between the register bank and step timer
`timescale 1ns/1ps
interface cvs_ramp_if;
  logic       start;     // One-cycle pulse, begin a ramp
  logic [2:0] rate;      // Ramp code, read again at every step
  logic       busy;      // Ramp in progress
  logic       done;      // One-cycle pulse, ramp complete
  modport bank  (output start, output rate, input busy, input done);
  modport timer (input start, input rate, output busy, output done);
endinterface : cvs_ramp_if

// ===== hw/cvs_ramp_timer.sv
// Step timer that paces a ramped voltage change of the two core bucks
`timescale 1ns/1ps
module cvs_ramp_timer
  import cvs_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Step count of the requested transition
  input  wire logic [7:0] steps,
  // Ramp port
  cvs_ramp_if.timer   rp
);
  typedef enum logic [0:0] {CVS_IDLE = 1'b0, CVS_RUN = 1'b1} cvs_tst_t;
  cvs_tst_t                 st_q, st_d;      // Timer state
  logic [CVS_STEP_W-1:0]    tick_q, tick_d;  // Cycles left in this step
  logic [7:0]               left_q, left_d;  // Steps left
  logic                     done_q, done_d;  // Completion pulse

  // Step length in cycles: 2.5 us base doubled per code below 6
  function automatic logic [CVS_STEP_W-1:0] step_len(input logic [2:0] code);
    logic [CVS_STEP_W-1:0] base;
    base     = CVS_STEP_W'(CVS_STEP_MIN_CYC);
    step_len = base << (3'd6 - code);
  endfunction : step_len

  // Next-state logic
  always_comb begin
    st_d   = st_q;
    tick_d = tick_q;
    left_d = left_q;
    done_d = 1'b0;
    unique case (st_q)
      CVS_IDLE: begin
        if (rp.start) begin
          // Immediate code or no distance finishes at once
          if (rp.rate == CVS_RAMP_IMMED || steps == 8'h00) begin
            done_d = 1'b1;
          end else begin
            st_d   = CVS_RUN;
            tick_d = step_len(rp.rate) - CVS_STEP_W'(1);
            left_d = steps;
          end
        end
      end
      CVS_RUN: begin
        if (tick_q != '0) begin
          tick_d = tick_q - CVS_STEP_W'(1);
        end else if (left_q == 8'h01) begin
          st_d   = CVS_IDLE;
          done_d = 1'b1;
        end else begin
          left_d = left_q - 8'h01;
          tick_d = step_len(rp.rate) - CVS_STEP_W'(1);
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= CVS_IDLE;
      tick_q <= '0;
      left_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      tick_q <= tick_d;
      left_q <= left_d;
      done_q <= done_d;
    end
  end

  assign rp.busy = (st_q == CVS_RUN);
  assign rp.done = done_q;
endmodule : cvs_ramp_timer

// ===== verif/cvs_host.sv
// Partner model: host byte transfers into the register pair
`timescale 1ns/1ps
module cvs_host
  import cvs_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Register access
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            unlocked,
  input  wire logic [7:0] rdata
);
  // Idle and locked at start
  initial begin
    {wr_en, rd_en, unlocked} = 3'h0;
    {addr, wdata} = 16'h0000;
  end
  // Password sequence finished before protected writes
  task automatic unlock();
    @(posedge clk);
    unlocked <= 1'b1;
  endtask : unlock
  // One byte; released lines go inverted so stale values never match
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] v;
    v = d;
    // No reserved codes; converter taken as disabled while recoded
    if (!rd && a == CVS_BB_ADDR && v[5:0] > CVS_BB_CODE_MAX) v[5:0] = CVS_BB_CODE_MAX;
    @(posedge clk);
    {wr_en, rd_en} <= {!rd, rd};
    {addr, wdata} <= {a, v};
    @(posedge clk);
    {wr_en, rd_en} <= 2'h0;
    {addr, wdata} <= {~a, ~v};
    #1 q = rdata;
  endtask : xfer
endmodule : cvs_host

// ===== verif/cvs_regs_chk.sv
// Checker: port properties of the converter register pair
`timescale 1ns/1ps
module cvs_regs_chk
  import cvs_pkg::*;
#(
  parameter int BLANK_CYC = CVS_BLANK_CYC  // Blanking span
) (
  // Clock, reset, access
  input wire logic       REF_CLK,
  input wire logic       RSTN,
  input wire logic       WR_EN,
  input wire logic       RD_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic       UNLOCKED,
  // Converter controls
  input wire logic       BUCKBOOST_PFM,
  input wire logic [5:0] BUCKBOOST_CODE,
  input wire logic       BUCKBOOST_MON_BLANK,
  input wire logic       CORE_RAMP_ACTIVE,
  input wire logic       CORE_APPLY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  wire       bb_wr = WR_EN && ADDR == CVS_BB_ADDR;  // Buck-boost write
  wire       wd_pfm = WDATA[7];                     // Written mode bit
  wire [5:0] wd_code = WDATA[5:0];                  // Written code
  int        gap_q, gap_d;                          // Age of last write, saturating
  // Age counter; any buck-boost write restarts it, so locked writes never cause false fails
  always_comb begin
    gap_d = (gap_q > BLANK_CYC) ? gap_q : gap_q + 1;
    if (bb_wr) gap_d = 0;
  end
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) gap_q <= BLANK_CYC + 1;
    else gap_q <= gap_d;
  end
  // Go with immediate rate on idle cores
  sequence s_go_immed;
    WR_EN && ADDR == CVS_RAMP_ADDR && WDATA[7] && WDATA[2:0] == 3'h7 && !CORE_RAMP_ACTIVE;
  endsequence
  // Apply strobe of one cycle
  sequence s_apply_once;
    CORE_APPLY ##1 !CORE_APPLY;
  endsequence
  a_go_immed: assert property (s_go_immed |-> ##3 s_apply_once)
    else $error("immediate apply missing");
  a_blank_start: assert property (bb_wr && UNLOCKED |=> BUCKBOOST_MON_BLANK [*8])
    else $error("blanking missing");
  a_blank_end: assert property (gap_q > BLANK_CYC |-> !BUCKBOOST_MON_BLANK)
    else $error("blanking too long");
  a_locked_hold: assert property (bb_wr && !UNLOCKED |=>
    $stable(BUCKBOOST_CODE) && $stable(BUCKBOOST_PFM))
    else $error("locked write landed");
  a_bb_write: assert property (bb_wr && UNLOCKED |=>
    {BUCKBOOST_PFM, BUCKBOOST_CODE} == {$past(wd_pfm), $past(wd_code)})
    else $error("write not applied");
  a_bb_read: assert property (RD_EN && !WR_EN && ADDR == CVS_BB_ADDR |=>
    RDATA == {$past(BUCKBOOST_PFM), 1'b0, $past(BUCKBOOST_CODE)})
    else $error("read data wrong");
  a_ramp_resv: assert property (RD_EN && ADDR == CVS_RAMP_ADDR |=> RDATA[5:3] == 3'h0)
    else $error("reserved bits set");
  a_reset_dflt: assert property ($rose(RSTN) |->
    BUCKBOOST_PFM && BUCKBOOST_CODE == CVS_BB_CODE_RST)
    else $error("reset value wrong");
endmodule : cvs_regs_chk

// ===== verif/cvs_regs_tb_top.sv
// Testbench: random and corner traffic into the converter register pair
`timescale 1ns/1ps
module cvs_regs_tb_top;
  import cvs_pkg::*;
  localparam int BLANK = 20;  // Shortened blanking span
  logic       clk, rstn, wr_en, rd_en, unl, code_wr, apply, blank, act, pfm, strap;
  logic [7:0] addr, wdata, rdata, steps, q, d;
  logic [5:0] code, alt;
  int         n_fail = 0, check_count = 0, n;
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  cvs_host i_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .unlocked(unl), .rdata(rdata));
  cvs_regs #(.BLANK_CYC(BLANK)) i_dut (.REF_CLK(clk), .RSTN(rstn), .WR_EN(wr_en),
    .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .UNLOCKED(unl),
    .CORE_CODE_WR(code_wr), .CORE_STEPS(steps), .RESISTOR_DEFAULT_SELECT(strap),
    .STRAP_ALT_CODE(alt), .BUCKBOOST_PFM(pfm), .BUCKBOOST_CODE(code),
    .BUCKBOOST_MON_BLANK(blank), .CORE_RAMP_ACTIVE(act), .CORE_APPLY(apply));
  // Cycles per step of a ramp code
  function automatic int ramp_cyc(input int r);
    return (r == 7) ? 0 : 25 << (6 - r);
  endfunction : ramp_cyc
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // Cycles until the apply strobe, bounded
  task automatic wait_apply(output int c);
    c = 0;
    while (apply !== 1'b1 && c < 6000) begin
      @(posedge clk);
      #1 c++;
    end
  endtask : wait_apply
  task automatic complete_run();
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // Watchdog well above the slowest ramp sweep
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    {rstn, code_wr, strap, steps, alt} = 17'h0_0000;
    void'($urandom(32'h4A78_F316));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    i_host.xfer(1'b1, CVS_BB_ADDR, 8'h00, q);
    check("bb_reset", CVS_BB_RESET, q);
    i_host.xfer(1'b1, CVS_RAMP_ADDR, 8'h00, q);
    check("ramp_reset", CVS_RAMP_RESET, q);
    i_host.xfer(1'b1, 8'h1B, 8'h00, q);
    check("unmapped", 8'h00, q);
    i_host.xfer(1'b0, CVS_BB_ADDR, 8'h2A, q);
    i_host.xfer(1'b1, CVS_BB_ADDR, 8'h00, q);
    check("bb_locked", CVS_BB_RESET, q);
    i_host.unlock();
    // Top code and reserved bit first, then random codes in range
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'h34 : (i == 1) ? 8'h40 : {8'($urandom) & 8'hC0} | 8'($urandom_range(52));
      i_host.xfer(1'b0, CVS_BB_ADDR, d, q);
      i_host.xfer(1'b1, CVS_BB_ADDR, 8'h00, q);
      check("bb_rw", d & CVS_BB_WMASK, q);
      check("blank_on", 8'h01, {7'h00, blank});
    end
    repeat (BLANK + 3) @(posedge clk);
    #1 check("blank_off", 8'h00, {7'h00, blank});
    // Every ramp code, step count drawn at random
    for (int r = 0; r < 8; r++) begin
      @(posedge clk);
      steps <= 8'(1 + $urandom_range(2));
      i_host.xfer(1'b0, CVS_RAMP_ADDR, 8'h80 | 8'(r), q);
      wait_apply(n);
      n -= int'(steps) * ramp_cyc(r);
      check("ramp_time", 8'h01, {7'h00, n >= 0 && n <= 8});
      i_host.xfer(1'b1, CVS_RAMP_ADDR, 8'h00, q);
      check("go_clear", 8'(r), q);
    end
    // Bypass with reserved bits written high
    i_host.xfer(1'b0, CVS_RAMP_ADDR, 8'h7E, q);
    i_host.xfer(1'b1, CVS_RAMP_ADDR, 8'h00, q);
    check("ramp_resv", 8'h46, q);
    @(posedge clk);
    // A core code raise, so no light-load bit is owed a clear first
    {steps, code_wr} <= {8'h01, 1'b1};
    @(posedge clk);
    code_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("ramp_active", 8'h01, {7'h00, act});
    wait_apply(n);
    check("bypass", 8'h01, {7'h00, n + 2 >= 25 && n + 2 <= 33});
    // Second reset with the strap high: the alternate code must load
    @(posedge clk);
    {strap, alt} <= {1'b1, 6'($urandom_range(52))};
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    i_host.xfer(1'b1, CVS_BB_ADDR, 8'h00, q);
    check("strap_code", {2'b10, alt}, q);
    check("code_pin", {2'b00, alt}, {2'b00, code});
    complete_run();
  end
endmodule : cvs_regs_tb_top

bind cvs_regs cvs_regs_chk #(.BLANK_CYC(BLANK_CYC)) u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN),
  .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA),
  .UNLOCKED(UNLOCKED), .BUCKBOOST_PFM(BUCKBOOST_PFM), .BUCKBOOST_CODE(BUCKBOOST_CODE),
  .BUCKBOOST_MON_BLANK(BUCKBOOST_MON_BLANK), .CORE_RAMP_ACTIVE(CORE_RAMP_ACTIVE),
  .CORE_APPLY(CORE_APPLY));
